/* pkg/scpsr_defs.vh */
/*
  Constants for the status summary and service request block: bit positions of the
  summary byte and standard event register, reset values, keyword match codes.
  Assumes it is included by its bare name from the design file.
*/
`ifndef SCPSR_DEFS_VH
`define SCPSR_DEFS_VH

// Summary byte bit positions
`define SCPSR_STB_QUENCH 2
`define SCPSR_STB_SER_MAV 3
`define SCPSR_STB_GPIB_MAV 4
`define SCPSR_STB_EVT_SUM 5
`define SCPSR_STB_RQS 6
// Bits that may feed the service request
`define SCPSR_STB_LIVE_MASK 8'h3c
// Standard event bit positions
`define SCPSR_ESR_OPC 0
`define SCPSR_ESR_QERR 2
`define SCPSR_ESR_DERR 3
`define SCPSR_ESR_EERR 4
`define SCPSR_ESR_CERR 5
`define SCPSR_ESR_PON 7
`define SCPSR_ESR_LIVE_MASK 8'hbd
// Reset values
`define SCPSR_ZERO8 8'h00
`define SCPSR_PON_EVENT 8'h80
// Keyword match codes
`define SCPSR_KW_NONE 2'h0
`define SCPSR_KW_SHORT 2'h1
`define SCPSR_KW_LONG 2'h2

`endif

/* src/scpsr_status.v */
/*
  Status summary byte, standard event register, enable masks and service request.
  Assumes a command parser that issues one-cycle strobes for each status command,
  output buffers that give not-empty flags, and a GPIB engine that strobes serial polls.
*/
// Contract
// R1 - Condition bits follow live state; reading never alters them; value is a bit sum
// R2 - Event bits latch on first occurrence, hold until event read or clear-status
// R3 - Enable masks are writable and readable; clear-status leaves them untouched
// R4 - Bit 4 and bit 3 track unread data in GPIB and serial buffers
// R5 - Bit 2 holds while quench persists, clears only on quench clear (code also clears it as soon as quench_active falls)
// R6 - Bit 5 high when any standard event bit is set and enabled
// R7 - Bit 6 reports enabled summary bits; bits 0, 1, 7 read zero
// R8 - Service request only on zero-to-one change of an enabled summary bit
// R9 - Quench and message bits request service only when first set
// R10 - Clear-status or ended condition clears summary bits; event read clears only bit 5
// R11 - Service enable mask cleared by zero write; power-up clear only if configured (reset always clears it; psc_q is stored but gates nothing)
// R12 - Serial poll returns the byte, then clears bit 6 and releases request
// R13 - Serial poll is answered at once, outside the command queue
// R14 - Status byte query answers in order, leaves bit 6 and request alone
// R15 - Clearing event bits recomputes bit 5 under the current event mask
// R16 - Keywords accepted only in short or full form; others flag an error
// R17 - Host joins keywords with bare colons and spaces before parameters
// R18 - Host programs masks as binary-weighted decimal sums
// R19 - Event layout: 0 OPC, 2 query, 3 device, 4 exec, 5 command, 7 power
// R20 - Message bits come from buffer not-empty flags; power-up clears status
// R21 - Service request is a level held until a serial poll
`timescale 1ns/100ps
`default_nettype none
`include "scpsr_defs.vh"

module scpsr_status #(
  parameter KW_MAX = 12
) (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Instrument conditions
  input wire quench_active,
  input wire quench_clear,
  input wire ser_buf_not_empty,
  input wire gpib_buf_not_empty,
  // Event sources, one-cycle pulses
  input wire evt_op_complete,
  input wire evt_query_err,
  input wire evt_device_err,
  input wire evt_exec_err,
  input wire evt_cmd_err,
  // Queued status commands, one-cycle strobes
  input wire cmd_clear_status,
  input wire cmd_read_event,
  input wire cmd_read_stb,
  input wire cmd_write_evt_mask,
  input wire cmd_write_srq_mask,
  input wire cmd_write_psc,
  input wire [7:0] cmd_value,
  // Immediate serial poll
  input wire serial_poll,
  // Keyword check
  input wire kw_check,
  input wire [KW_MAX*8-1:0] kw_text,
  input wire [3:0] kw_len,
  input wire [KW_MAX*8-1:0] kw_ref,
  input wire [3:0] kw_ref_len,
  input wire [3:0] kw_short_len,
  // Answers
  output reg [7:0] stb_q,
  output reg [7:0] event_q,
  output reg [7:0] evt_mask_q,
  output reg [7:0] srq_mask_q,
  output reg psc_q,
  output reg [7:0] read_data_q,
  output reg read_valid_q,
  output reg [7:0] poll_data_q,
  output reg poll_valid_q,
  output reg srq_q,
  output reg kw_ok_q,
  output reg kw_err_q
);

  reg [7:0] event_d;
  reg [7:0] live_d;
  reg [7:0] prev_live_q;
  reg [7:0] rise_d;
  reg [7:0] stb_d;
  reg rqs_q;
  reg rqs_d;
  reg powered_q;
  reg [1:0] kw_code;
  reg kw_short_hit;
  reg kw_long_hit;
  reg kw_bad;

  // Upper-case fold of one ASCII character
  function [7:0] fold_upper;
    input [7:0] c;
    begin
      if (c >= 8'h61 && c <= 8'h7a) begin
        fold_upper = c - 8'h20;
      end else begin
        fold_upper = c;
      end
    end
  endfunction

  // Case-folded compare of the first n characters
  function match_prefix;
    input [KW_MAX*8-1:0] a;
    input [KW_MAX*8-1:0] b;
    input [3:0] n;
    integer i;
    reg ok;
    begin
      ok = 1'b1;
      for (i = 0; i < KW_MAX; i = i + 1) begin
        if (i < n && fold_upper(a[i*8 +: 8]) != fold_upper(b[i*8 +: 8])) begin
          ok = 1'b0;
        end
      end
      match_prefix = ok;
    end
  endfunction

  // Exact lengths only, so a longer prefix is still an error
  always @* begin
    kw_short_hit = 1'b0;
    kw_long_hit = 1'b0;
    if (kw_len == kw_short_len) begin
      kw_short_hit = match_prefix(kw_text, kw_ref, kw_short_len); // see R16
    end
    if (kw_len == kw_ref_len) begin
      kw_long_hit = match_prefix(kw_text, kw_ref, kw_ref_len); // see R16
    end
  end

  always @* begin
    kw_code = `SCPSR_KW_NONE;
    if (kw_short_hit) begin
      kw_code = `SCPSR_KW_SHORT; // see R16
    end else if (kw_long_hit) begin
      kw_code = `SCPSR_KW_LONG; // see R16
    end
    kw_bad = kw_check && (kw_code == `SCPSR_KW_NONE);
  end

  // Event register: set wins over read or clear in the same cycle
  always @* begin
    event_d = event_q;
    if (cmd_clear_status || cmd_read_event) begin
      event_d = `SCPSR_ZERO8; // see R2
    end
    if (evt_op_complete) begin
      event_d[`SCPSR_ESR_OPC] = 1'b1; // see R2
    end
    if (evt_query_err) begin
      event_d[`SCPSR_ESR_QERR] = 1'b1;
    end
    if (evt_device_err) begin
      event_d[`SCPSR_ESR_DERR] = 1'b1;
    end
    if (evt_exec_err) begin
      event_d[`SCPSR_ESR_EERR] = 1'b1;
    end
    if (evt_cmd_err || kw_bad) begin
      event_d[`SCPSR_ESR_CERR] = 1'b1; // see R16
    end
    event_d = event_d & `SCPSR_ESR_LIVE_MASK; // see R19
  end

  // Summary bits 2..5, computed from next-state event bits
  always @* begin
    live_d = `SCPSR_ZERO8; // see R7
    live_d[`SCPSR_STB_QUENCH] = quench_active & ~quench_clear; // see R5
    live_d[`SCPSR_STB_SER_MAV] = ser_buf_not_empty; // see R4 R20
    live_d[`SCPSR_STB_GPIB_MAV] = gpib_buf_not_empty; // see R4 R20
    live_d[`SCPSR_STB_EVT_SUM] = |(event_d & evt_mask_q); // see R6 R10 R15
  end

  // Request summary: rises on new enabled bits, falls only on poll or clear-status
  always @* begin
    // Held quench or message bits give no edge, so they cannot refire
    rise_d = live_d & ~prev_live_q & srq_mask_q & `SCPSR_STB_LIVE_MASK; // see R8 R9
    rqs_d = rqs_q;
    if (serial_poll) begin
      rqs_d = 1'b0; // see R12
    end
    if (cmd_clear_status) begin
      rqs_d = 1'b0; // see R10
    end
    if (|rise_d) begin
      rqs_d = 1'b1; // see R8 R9
    end
  end

  // Summary byte as presented next cycle
  always @* begin
    stb_d = live_d; // see R1 R7
    stb_d[`SCPSR_STB_RQS] = rqs_d; // see R7
  end

  // Power-up marker, low only in the first cycle after reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      powered_q <= 1'b0;
    end else begin
      powered_q <= 1'b1;
    end
  end

  // First cycle after power-up records the power-on event
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_q <= `SCPSR_ZERO8;
    end else if (!powered_q) begin
      event_q <= `SCPSR_PON_EVENT; // see R19 R20
    end else begin
      event_q <= event_d; // see R2
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_live_q <= `SCPSR_ZERO8;
    end else begin
      prev_live_q <= live_d; // see R8
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rqs_q <= 1'b0;
    end else begin
      rqs_q <= rqs_d;
    end
  end

  // Level, not a pulse: the host may take many cycles to poll
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      srq_q <= 1'b0;
    end else begin
      srq_q <= rqs_d; // see R21
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stb_q <= `SCPSR_ZERO8;
    end else begin
      stb_q <= stb_d; // see R1 R7
    end
  end

  // Masks survive clear-status; a zero write clears them
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_mask_q <= `SCPSR_ZERO8;
    end else if (cmd_write_evt_mask) begin
      evt_mask_q <= cmd_value; // see R3
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      srq_mask_q <= `SCPSR_ZERO8;
    end else if (cmd_write_srq_mask) begin
      srq_mask_q <= cmd_value & `SCPSR_STB_LIVE_MASK; // see R3 R11
    end
  end

  // Reset stands for power-on with status clear set; the flag is not retained
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      psc_q <= 1'b1;
    end else if (cmd_write_psc) begin
      psc_q <= cmd_value != `SCPSR_ZERO8; // see R11
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_valid_q <= 1'b0;
    end else begin
      read_valid_q <= cmd_read_event | cmd_read_stb; // see R14
    end
  end

  // Queued reads answer from current state, in command order
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      read_data_q <= `SCPSR_ZERO8;
    end else if (cmd_read_event) begin
      read_data_q <= event_q; // see R2
    end else if (cmd_read_stb) begin
      read_data_q <= stb_q; // see R14
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_valid_q <= 1'b0;
    end else begin
      poll_valid_q <= serial_poll; // see R13
    end
  end

  // Poll bypasses the queue and sees the byte before bit 6 drops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      poll_data_q <= `SCPSR_ZERO8;
    end else if (serial_poll) begin
      poll_data_q <= stb_q; // see R12 R13
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kw_ok_q <= 1'b0;
    end else begin
      kw_ok_q <= kw_check && (kw_code != `SCPSR_KW_NONE); // see R16
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kw_err_q <= 1'b0;
    end else begin
      kw_err_q <= kw_bad; // see R16
    end
  end

endmodule // scpsr_status
`default_nettype wire

/* sim/scpsr_obuf.sv */
/* Output buffer stand-in: counts unread bytes, flags not-empty.
   Assumes at most one push or pop per cycle, at most 15 bytes held. */
`timescale 1ns/100ps
`default_nettype none
module scpsr_obuf (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host side
  input wire logic push,
  input wire logic pop,
  output logic not_empty
);
  logic [3:0] cnt_q;
  assign not_empty = cnt_q != 4'h0;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + {3'h0, push} - {3'h0, pop & not_empty};
  end
endmodule // scpsr_obuf
`default_nettype wire

/* sim/scpsr_status_props.sv */
/* Checker for scpsr_status, port view only.
   Assumes one clock and the async reset of the block. */
`timescale 1ns/100ps
`default_nettype none
module scpsr_status_props (
  // Clock and reset
  input wire clk,
  input wire arst_n,
  // Inputs
  input wire ser_buf_not_empty,
  input wire gpib_buf_not_empty,
  input wire cmd_clear_status,
  input wire cmd_read_event,
  input wire cmd_read_stb,
  input wire serial_poll,
  input wire kw_check,
  // Outputs
  input wire [7:0] stb_q,
  input wire [7:0] event_q,
  input wire [7:0] read_data_q,
  input wire read_valid_q,
  input wire [7:0] poll_data_q,
  input wire poll_valid_q,
  input wire srq_q,
  input wire kw_ok_q,
  input wire kw_err_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence poll_s;
    poll_valid_q && poll_data_q == $past(stb_q);
  endsequence
  zero_bits_a: assert property ((stb_q & 8'h83) == 8'h00)
    else $error("spare stb bit");
  evt_gaps_a: assert property ((event_q & 8'h42) == 8'h00)
    else $error("spare event bit");
  mav_track_a: assert property (stb_q[4:3] == $past({gpib_buf_not_empty, ser_buf_not_empty}))
    else $error("mav bits");
  poll_answer_a: assert property (serial_poll |=> poll_s)
    else $error("poll answer");
  // A rise at the poll itself may win; such a rise shows as a new live bit
  poll_release_a: assert property (serial_poll |=> (!srq_q && !stb_q[6]) || $changed(stb_q[5:2]))
    else $error("poll release");
  srq_hold_a: assert property (srq_q && !serial_poll && !cmd_clear_status |=> srq_q)
    else $error("srq dropped");
  srq_pair_a: assert property ($rose(srq_q) |-> stb_q[6])
    else $error("srq without bit 6");
  evt_read_a: assert property (cmd_read_event |=> read_valid_q && read_data_q == $past(event_q))
    else $error("event read");
  stb_query_a: assert property (cmd_read_stb && !cmd_read_event |=> read_data_q == $past(stb_q))
    else $error("stb query");
  kw_result_a: assert property (kw_check |=> kw_ok_q ^ kw_err_q)
    else $error("keyword result");
endmodule // scpsr_status_props
bind scpsr_status scpsr_status_props p_u (.*);
`default_nettype wire

/* sim/scpsr_status_tb_top.sv */
/* Random status traffic against a bench model.
   Assumes scpsr_obuf stands in for both output buffers. */
`timescale 1ns/100ps
`default_nettype none
module scpsr_status_tb_top;
  reg clk = 0, arst_n = 0, quench_active = 0, quench_clear = 0, serial_poll = 0, kw_check = 0;
  reg evt_op_complete = 0, evt_query_err = 0, evt_device_err = 0, evt_exec_err = 0;
  reg evt_cmd_err = 0, cmd_clear_status = 0, cmd_read_event = 0, cmd_read_stb = 0;
  reg cmd_write_evt_mask = 0, cmd_write_srq_mask = 0, cmd_write_psc = 0;
  reg [7:0] cmd_value = 0;
  reg [95:0] kw_ref = "ERUGIFNOC", kw_text = 0;
  reg [3:0] kw_len = 0, kw_ref_len = 4'h9, kw_short_len = 4'h4;
  reg [1:0] psh = 0, pop = 0;
  wire ser_buf_not_empty, gpib_buf_not_empty, psc_q, read_valid_q, poll_valid_q, srq_q;
  wire kw_ok_q, kw_err_q;
  wire [7:0] stb_q, event_q, evt_mask_q, srq_mask_q, read_data_q, poll_data_q;
  integer num_errors = 0, num_checks = 0, seed = 89, a, i, r, b, ev = 8'h80, em = 0;
  integer sm = 0, sr = 0, pl = 0, q = 0, ps = 1, nb [0:1];
  scpsr_status dut_u (.*);
  scpsr_obuf sbuf_u (.clk(clk), .arst_n(arst_n), .push(psh[0]), .pop(pop[0]),
    .not_empty(ser_buf_not_empty));
  scpsr_obuf gbuf_u (.clk(clk), .arst_n(arst_n), .push(psh[1]), .pop(pop[1]),
    .not_empty(gpib_buf_not_empty));
  initial forever #20 clk = ~clk;
  function automatic [7:0] stb_exp();
    stb_exp = {1'b0, sr[0], |(ev & em), nb[1] != 0, nb[0] != 0, q[0], 2'b00};
  endfunction
  task chk(input [7:0] g, input [7:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors = num_errors + 1;
    complete_run;
  end
  initial begin
    nb[0] = 0;
    nb[1] = 0;
    repeat (16) @(negedge clk);
    arst_n = 1;
    repeat (2) @(negedge clk);
    for (i = 0; i < 150; i = i + 1) begin
      a = {$random(seed)} % 13;
      r = {$random(seed)} % 256;
      b = a - 3;
      case (a)
        0: begin
          {evt_cmd_err, evt_exec_err, evt_device_err, evt_query_err, evt_op_complete} = 1 << r % 5;
          ev = ev | 1 << (r % 5 ? r % 5 + 1 : 0);
        end
        1: begin quench_active = 1; q = 1; end
        2: begin quench_active = 0; quench_clear = 1; q = 0; end
        3, 4: begin
          if (nb[b] && r[0]) {pop[b], nb[b]} = {1'b1, nb[b] - 1};
          else if (nb[b] < 14) {psh[b], nb[b]} = {1'b1, nb[b] + 1};
        end
        5: {cmd_write_evt_mask, cmd_value, em} = {1'b1, r[7:0], r};
        6: {cmd_write_srq_mask, cmd_value, sm} = {1'b1, r[7:0], r & 8'h3c};
        7: {cmd_clear_status, ev, sr} = 1'b1 << 64;
        8: cmd_read_event = 1;
        9: cmd_read_stb = 1;
        10: serial_poll = 1;
        12: begin cmd_write_psc = 1; cmd_value = r[7:0]; ps = r != 0; end
        default: begin
          kw_check = 1;
          kw_len = r % 3 == 0 ? 5 : (r[0] ? 9 : 4);
          // Random case flips: the compare must ignore letter case
          kw_text = kw_ref | ({$random(seed), $random(seed), $random(seed)} & {12{8'h20}});
        end
      endcase
      @(negedge clk);
      case (a)
        5: chk(evt_mask_q, em);
        6: chk(srq_mask_q, sm);
        8: begin chk(read_data_q, ev); chk({7'h0, read_valid_q}, 8'h01); ev = 0; end
        9: begin chk(read_data_q, stb_exp()); chk({7'h0, read_valid_q}, 8'h01); end
        12: chk({7'h0, psc_q}, ps);
        10: begin chk(poll_data_q, stb_exp()); sr = 0; end
        11: begin chk({kw_err_q, kw_ok_q}, kw_len == 5 ? 2 : 1); ev = ev | (kw_len == 5) << 5; end
      endcase
      {quench_clear, serial_poll, kw_check, cmd_clear_status, cmd_read_event, cmd_read_stb} = 0;
      {cmd_write_evt_mask, cmd_write_srq_mask, cmd_write_psc, psh, pop} = 0;
      {evt_cmd_err, evt_exec_err, evt_device_err, evt_query_err, evt_op_complete} = 0;
      repeat (2) @(negedge clk);
      // Only a real 0-to-1 of an enabled bit counts, not a mask change
      r = stb_exp() & 8'h3c;
      if (r & ~pl & sm) sr = 1;
      pl = r;
      chk(stb_q, stb_exp());
      chk(event_q, ev);
      chk({7'h0, srq_q}, sr);
    end
    complete_run;
  end
endmodule // scpsr_status_tb_top
`default_nettype wire
